// ===== bwd_pkg.sv
// bwd_pkg: constants, carriers and state types of the dma controller
// assumes a single 125 MHz core clock and pin-level open-drain handling
package bwd_pkg;
	// data path width of the shared data access lines
	localparam int DATA_W = 8;
	// register indices, selected by the three low select bits
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_TC_LO = 3'h2;
	localparam logic [2:0] REG_TC_HI = 3'h3;
	localparam logic [2:0] REG_MA_LO = 3'h4;
	localparam logic [2:0] REG_MA_HI = 3'h5;
	localparam logic [2:0] REG_MA_EXT = 3'h6;
	localparam logic [2:0] REG_ID = 3'h7;
	// select bit that addresses the controller itself
	localparam int SEL_SELF = 3;
	// control register fields
	localparam int CR_RUN = 0;
	localparam int CR_DIE = 1;
	localparam int CR_TOIE = 2;
	localparam int CR_TCIE = 3;
	localparam int CR_IOM = 4;
	localparam int CR_HBUS = 5;
	localparam int CR_AECE = 6;
	// status register fields that software may write
	localparam int SR_DINT = 1;
	localparam int SR_TOI = 2;
	// reset values: read mode, hold bus, carry enable, count of one
	localparam logic [7:0] CTRL_RST = 8'h70;
	localparam logic [7:0] CTRL_WMASK = 8'h7f;
	localparam logic [15:0] TC_RST = 16'h0001;
	localparam logic [17:0] MAR_RST = 18'h00000;
	localparam logic [7:0] ID_RST = 8'h00;
	// bits forced on by an auto load
	localparam logic [7:0] CTRL_AUTO = 8'h0b;
	// reply time-out, 5 us, rounded down to whole clocks
	localparam int CLK_PERIOD_NS = 8;
	localparam int TMO_NS = 5000;
	localparam int TMO_W = 10;
	localparam logic [TMO_W-1:0] TMO_CYC =
		TMO_W'(TMO_NS / CLK_PERIOD_NS);
	// transfer sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_REQ,
		ST_ADDR_LO,
		ST_SYNC,
		ST_DONE
	} bwd_fsm_t;
	// pin inputs travelling together through the synchroniser
	typedef struct packed {
		logic xfer_request_in;
		logic bus_grant_in_n;
		logic stop_request_n;
		logic int_ack_in_n;
		logic periph_int_in;
		logic byte_word_sel;
		logic auto_boot_load;
		logic data_polarity_sel;
		logic chip_select_n;
		logic [3:0] reg_select;
		logic read_strobe_n;
		logic write_strobe_n;
		logic reply_n;
		logic [7:0] dal;
	} bwd_pins_t;
	// idle level of the pins: active-low lines high, true data bus
	localparam bwd_pins_t PINS_IDLE = 24'h758700;
	// whole state of the controller
	typedef struct packed {
		bwd_fsm_t fsm;
		logic [7:0] ctrl;
		logic dint;
		logic toi;
		logic tczi;
		logic [15:0] tc;
		logic [17:0] mar;
		logic [7:0] idr;
		logic bus_request_n;
		logic int_request_n;
		logic [TMO_W-1:0] tmo;
		logic we_d;
		logic ald_d;
		logic reply;
		logic [7:0] dal;
		logic dal_oe;
		logic ae;
		logic addr_low_strobe_n;
		logic mem_sync_n;
		logic mem_read_n;
		logic mem_write_n;
		logic prd;
		logic pwr;
		logic periph_select_n;
	} bwd_state_t;
endpackage

// ===== bwd_sync.sv
// bwd_sync: two-flop synchroniser for a bundle of pin inputs
// assumes the bits are independent levels; no bus coherence is implied
`timescale 1ns/100ps
`default_nettype none
module bwd_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// both stages of the synchroniser
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} bwd_sync_t;
	bwd_sync_t s; // registered state
	bwd_sync_t next_s; // next state
	// first stage feeds only the second
	always_comb begin
		next_s.meta = d_i;
		next_s.q = s.meta;
	end
	// register both stages; reset to the pins' idle levels
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			s <= {RST, RST};
		end else begin
			s <= next_s;
		end
	end
	assign q_o = s.q;
endmodule // bwd_sync
`default_nettype wire

// ===== bwd_dmac.sv
// bwd_dmac: single channel dma controller with cpu register access
// assumes open-drain wires resolved outside; pins asynchronous to clock
//
// Summary of operation
// [R1] data request starts a bus request
// [R2] low grant while requesting starts transfer
// [R3] grant passes through when not requesting
// [R4] high select bit picks controller, else peripheral
// [R5] host asserts chip select before any access
// [R6] bus request latches high address byte
// [R7] address low strobe latches low byte
// [R8] strobes are inputs for cpu, outputs dma
// [R9] memory read or write by transfer direction
// [R10] memory sync starts access, then await reply
// [R11] direction output follows control bit four
// [R12] stop request blocks new interrupt, bus requests
// [R13] acknowledged interrupt puts id on data
// [R14] acknowledge passes through when not interrupting
// [R15] polarity select low inverts data lines
// [R16] extension bit carries top address, same polarity
// [R17] data lines float when peripheral addressed
// [R18] byte adds one, word adds two
// [R19] auto load starts unprogrammed block transfer
// [R20] end of block at count zero
// [R21] interrupt needs condition, enable, stop high
// [R22] index zero control, index one status
// [R23] reset clears all but defaults set
// [R24] auto load sets run, device and count enables
// [R25] synchronous logic, reset releases open drains
`timescale 1ns/100ps
`default_nettype none
module bwd_dmac (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic xfer_request_in_i,
	input wire logic bus_grant_in_n_i,
	input wire logic stop_request_n_i,
	input wire logic int_ack_in_n_i,
	input wire logic periph_int_in_i,
	input wire logic byte_word_sel_i,
	input wire logic auto_boot_load_i,
	input wire logic data_polarity_sel_i,
	input wire logic chip_select_n_i,
	input wire logic [3:0] reg_select_i,
	input wire logic read_strobe_n_i,
	output logic read_strobe_n_o,
	output logic read_strobe_n_oe_o,
	input wire logic write_strobe_n_i,
	output logic write_strobe_n_o,
	output logic write_strobe_n_oe_o,
	input wire logic reply_n_i,
	output logic reply_n_o,
	output logic reply_n_oe_o,
	input wire logic [bwd_pkg::DATA_W-1:0] data_access_lines_i,
	output logic [bwd_pkg::DATA_W-1:0] data_access_lines_o,
	output logic data_access_lines_oe_o,
	output logic addr_extension_bit_o,
	output logic bus_request_n_o,
	output logic addr_low_strobe_n_o,
	output logic bus_grant_out_n_o,
	output logic int_ack_out_n_o,
	output logic periph_select_n_o,
	output logic mem_read_n_o,
	output logic mem_read_n_oe_o,
	output logic mem_write_n_o,
	output logic mem_write_n_oe_o,
	output logic mem_sync_n_o,
	output logic mem_sync_n_oe_o,
	output logic int_request_n_o,
	output logic int_request_n_oe_o,
	output logic xfer_dir_o,
	output logic end_of_block_o
);
	import bwd_pkg::*;

	bwd_pins_t raw; // pins as they arrive
	bwd_pins_t p; // pins after two flops
	bwd_state_t s; // registered state
	bwd_state_t next_s; // next state
	logic [7:0] din; // data lines in true polarity
	logic [2:0] idx; // register index
	logic cpu_sel; // controller addressed by the cpu
	logic cpu_wr; // falling write strobe while addressed
	logic iack_sel; // selected through the acknowledge chain
	logic int_cond; // an enabled interrupt condition stands
	logic [7:0] rd_val; // register read value
	logic [7:0] stat; // composed status byte
	logic [16:0] lo_sum; // low address word plus step
	logic [15:0] tc_inc; // next transfer count
	logic protect; // address and count writes blocked

	// bundle the pin inputs
	assign raw = '{
		xfer_request_in: xfer_request_in_i,
		bus_grant_in_n: bus_grant_in_n_i,
		stop_request_n: stop_request_n_i,
		int_ack_in_n: int_ack_in_n_i,
		periph_int_in: periph_int_in_i,
		byte_word_sel: byte_word_sel_i,
		auto_boot_load: auto_boot_load_i,
		data_polarity_sel: data_polarity_sel_i,
		chip_select_n: chip_select_n_i,
		reg_select: reg_select_i,
		read_strobe_n: read_strobe_n_i,
		write_strobe_n: write_strobe_n_i,
		reply_n: reply_n_i,
		dal: data_access_lines_i
	};

	// two flops on every pin before logic reads it
	bwd_sync #(
		.W($bits(bwd_pins_t)),
		.RST(PINS_IDLE)
	) u_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.d_i(raw),
		.q_o(p)
	);

	// decode and helper values
	always_comb begin
		idx = p.reg_select[2:0];
		// [R15] polarity of incoming data
		din = p.data_polarity_sel ? p.dal : ~p.dal;
		// [R4] [R22] controller selected by high bit
		cpu_sel = ~p.chip_select_n & p.reg_select[SEL_SELF];
		cpu_wr = cpu_sel & ~p.write_strobe_n & s.we_d;
		// [R13] chosen by the acknowledge chain
		iack_sel = ~s.int_request_n & ~p.int_ack_in_n;
		// [R21] condition and its enable
		int_cond = (s.dint & s.ctrl[CR_DIE]) |
			(s.toi & s.ctrl[CR_TOIE]) |
			(s.tczi & s.ctrl[CR_TCIE]);
		stat = {s.ctrl[CR_RUN], s.ctrl[CR_AECE:CR_IOM],
			s.tczi, s.toi, s.dint, p.byte_word_sel};
		// [R18] step of one for bytes, two for words
		lo_sum = {1'b0, s.mar[15:0]} +
			(p.byte_word_sel ? 17'h00001 : 17'h00002);
		if (!p.byte_word_sel) begin
			lo_sum[0] = 1'b0;
		end
		tc_inc = s.tc + 16'h0001;
		protect = s.ctrl[CR_RUN];
		// register read mux
		unique case (idx)
			REG_CTRL: rd_val = s.ctrl;
			REG_STAT: rd_val = stat;
			REG_TC_LO: rd_val = s.tc[7:0];
			REG_TC_HI: rd_val = s.tc[15:8];
			REG_MA_LO: rd_val = s.mar[7:0];
			REG_MA_HI: rd_val = s.mar[15:8];
			REG_MA_EXT: rd_val = {6'h00, s.mar[17:16]};
			REG_ID: rd_val = s.idr;
		endcase
	end

	// next state of the whole controller
	always_comb begin
		next_s = s;
		// one-cycle and edge tracking defaults
		next_s.addr_low_strobe_n = 1'b1;
		next_s.we_d = p.write_strobe_n;
		next_s.ald_d = p.auto_boot_load;
		next_s.dal_oe = 1'b0;
		// cpu register write on the falling strobe
		if (cpu_wr) begin
			unique case (idx)
				REG_CTRL: next_s.ctrl = din & CTRL_WMASK;
				REG_STAT: begin
					next_s.dint = din[SR_DINT];
					next_s.toi = din[SR_TOI];
				end
				// address and count locked while running
				REG_TC_LO: if (!protect) next_s.tc[7:0] = din;
				REG_TC_HI: if (!protect) next_s.tc[15:8] = din;
				REG_MA_LO: if (!protect) next_s.mar[7:0] = din;
				REG_MA_HI: if (!protect) next_s.mar[15:8] = din;
				REG_MA_EXT: begin
					if (!protect) begin
						next_s.mar[17:16] = din[1:0];
					end
				end
				REG_ID: next_s.idr = din;
			endcase
		end
		// cpu handshake reply while a strobe is low
		next_s.reply = ~(cpu_sel &
			(~p.read_strobe_n | ~p.write_strobe_n));
		// [R13] id code on an acknowledged read
		if (iack_sel & ~p.read_strobe_n) begin
			next_s.dal = p.data_polarity_sel ? s.idr : ~s.idr;
			next_s.dal_oe = 1'b1;
		// [R17] only a controller read drives the lines
		end else if (cpu_sel & ~p.read_strobe_n) begin
			next_s.dal = p.data_polarity_sel ? rd_val : ~rd_val;
			next_s.dal_oe = 1'b1;
		end
		// [R24] [R19] auto load sets run and the device and count interrupt enables
		if (p.auto_boot_load & ~s.ald_d) begin
			next_s.ctrl = next_s.ctrl | CTRL_AUTO;
		end
		// device interrupt is sticky; set beats clear
		if (p.periph_int_in) begin
			next_s.dint = 1'b1;
			// an enabled device interrupt ends the block
			if (s.ctrl[CR_DIE]) begin
				next_s.ctrl[CR_RUN] = 1'b0;
			end
		end
		// [R21] [R12] interrupt asserts only with stop high
		if (!int_cond) begin
			next_s.int_request_n = 1'b1;
		end else if (p.stop_request_n) begin
			next_s.int_request_n = 1'b0;
		end
		// transfer sequencer
		unique case (s.fsm)
			ST_IDLE: begin
				// [R1] [R12] new bus request only with stop high
				if (s.ctrl[CR_RUN] & p.xfer_request_in &
					~s.tczi & p.stop_request_n) begin
					next_s.bus_request_n = 1'b0;
					// [R6] [R16] high byte and bit 17 out
					next_s.dal = p.data_polarity_sel ?
						s.mar[15:8] : ~s.mar[15:8];
					next_s.ae = s.mar[17] ~^ p.data_polarity_sel;
					next_s.dal_oe = 1'b1;
					next_s.fsm = ST_REQ;
				end
			end
			ST_REQ: begin
				next_s.dal_oe = 1'b1;
				// [R2] grant while requesting starts the cycle
				if (!p.bus_grant_in_n) begin
					// [R7] [R16] low byte and bit 16 out
					next_s.dal = p.data_polarity_sel ?
						s.mar[7:0] : ~s.mar[7:0];
					next_s.ae = s.mar[16] ~^ p.data_polarity_sel;
					next_s.addr_low_strobe_n = 1'b0;
					next_s.fsm = ST_ADDR_LO;
				end
			end
			ST_ADDR_LO: begin
				// [R10] [R9] [R8] open the memory access
				next_s.mem_sync_n = 1'b0;
				next_s.mem_write_n = ~s.ctrl[CR_IOM];
				next_s.mem_read_n = s.ctrl[CR_IOM];
				next_s.prd = ~s.ctrl[CR_IOM];
				next_s.pwr = s.ctrl[CR_IOM];
				next_s.periph_select_n = 1'b0;
				next_s.tmo = '0;
				next_s.fsm = ST_SYNC;
			end
			ST_SYNC: begin
				next_s.tmo = s.tmo + 1'b1;
				// [R10] reply ends the access
				if (!p.reply_n) begin
					// [R18] address step, carry gated by aece
					next_s.mar[15:0] = lo_sum[15:0];
					next_s.mar[17:16] = s.mar[17:16] +
						{1'b0, lo_sum[16] & s.ctrl[CR_AECE]};
					next_s.tc = tc_inc;
					// [R20] count reaching zero ends the block
					if (tc_inc == 16'h0000) begin
						next_s.tczi = 1'b1;
						next_s.ctrl[CR_RUN] = 1'b0;
					end
					next_s.fsm = ST_DONE;
				end else if (s.tmo == TMO_CYC - 1'b1) begin
					// no reply in time: flag and stop
					next_s.toi = 1'b1;
					next_s.ctrl[CR_RUN] = 1'b0;
					next_s.fsm = ST_DONE;
				end
			end
			ST_DONE: begin
				// release the memory and peripheral strobes
				next_s.mem_sync_n = 1'b1;
				next_s.mem_read_n = 1'b1;
				next_s.mem_write_n = 1'b1;
				next_s.prd = 1'b1;
				next_s.pwr = 1'b1;
				next_s.periph_select_n = 1'b1;
				// hold bus: keep it and present the next low address byte and bit 16
				if (s.ctrl[CR_HBUS] & s.ctrl[CR_RUN] &
					~s.tczi & p.xfer_request_in) begin
					next_s.dal = p.data_polarity_sel ?
						s.mar[7:0] : ~s.mar[7:0];
					next_s.ae = s.mar[16] ~^ p.data_polarity_sel;
					next_s.dal_oe = 1'b1;
					next_s.addr_low_strobe_n = 1'b0;
					next_s.fsm = ST_ADDR_LO;
				end else begin
					next_s.bus_request_n = 1'b1;
					next_s.fsm = ST_IDLE;
				end
			end
			default: next_s.fsm = ST_IDLE;
		endcase
	end

	// [R25] [R23] one register set; reset loads the defaults
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			s <= '{
				fsm: ST_IDLE,
				ctrl: CTRL_RST,
				dint: 1'b0,
				toi: 1'b0,
				tczi: 1'b0,
				tc: TC_RST,
				mar: MAR_RST,
				idr: ID_RST,
				bus_request_n: 1'b1,
				int_request_n: 1'b1,
				tmo: '0,
				we_d: 1'b1,
				ald_d: 1'b1,
				reply: 1'b1,
				dal: 8'h00,
				dal_oe: 1'b0,
				ae: 1'b0,
				addr_low_strobe_n: 1'b1,
				mem_sync_n: 1'b1,
				mem_read_n: 1'b1,
				mem_write_n: 1'b1,
				prd: 1'b1,
				pwr: 1'b1,
				periph_select_n: 1'b1
			};
		end else begin
			s <= next_s;
		end
	end

	// [R3] grant passes on unless this controller requests
	assign bus_grant_out_n_o = s.bus_request_n ? p.bus_grant_in_n : 1'b1;
	// [R14] acknowledge passes on unless interrupting
	assign int_ack_out_n_o = s.int_request_n ? p.int_ack_in_n : 1'b1;
	// [R4] peripheral select for cpu or dma access
	assign periph_select_n_o = s.periph_select_n &
		~(~p.chip_select_n & ~p.reg_select[SEL_SELF]);
	// [R11] direction straight from the control bit
	assign xfer_dir_o = s.ctrl[CR_IOM];
	// [R20] end of block follows the zero-count flag
	assign end_of_block_o = s.tczi;
	assign bus_request_n_o = s.bus_request_n;
	assign addr_low_strobe_n_o = s.addr_low_strobe_n;
	assign addr_extension_bit_o = s.ae;
	assign data_access_lines_o = s.dal;
	assign data_access_lines_oe_o = s.dal_oe;
	// [R8] strobes driven only in the dma data phase
	assign read_strobe_n_o = s.prd;
	assign read_strobe_n_oe_o = ~s.prd;
	assign write_strobe_n_o = s.pwr;
	assign write_strobe_n_oe_o = ~s.pwr;
	// open-drain lines pulled low only while active
	assign reply_n_o = s.reply;
	assign reply_n_oe_o = ~s.reply;
	assign mem_read_n_o = s.mem_read_n;
	assign mem_read_n_oe_o = ~s.mem_read_n;
	assign mem_write_n_o = s.mem_write_n;
	assign mem_write_n_oe_o = ~s.mem_write_n;
	assign mem_sync_n_o = s.mem_sync_n;
	assign mem_sync_n_oe_o = ~s.mem_sync_n;
	assign int_request_n_o = s.int_request_n;
	assign int_request_n_oe_o = ~s.int_request_n;
endmodule // bwd_dmac
`default_nettype wire

// ===== bwd_dmac_asserts.sv
// bwd_dmac_asserts: port-level checker for the dma controller
// assumes one clock domain and inputs two flops from their use
`timescale 1ns/100ps
`default_nettype none
module bwd_dmac_asserts (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic bus_grant_in_n_i,
	input wire logic int_ack_in_n_i,
	input wire logic stop_request_n_i,
	input wire logic chip_select_n_i,
	input wire logic [3:0] reg_select_i,
	input wire logic bus_request_n_o,
	input wire logic bus_grant_out_n_o,
	input wire logic int_ack_out_n_o,
	input wire logic int_request_n_o,
	input wire logic addr_low_strobe_n_o,
	input wire logic mem_sync_n_o,
	input wire logic mem_read_n_o,
	input wire logic mem_write_n_o,
	input wire logic xfer_dir_o,
	input wire logic periph_select_n_o,
	input wire logic data_access_lines_oe_o
);
	// every check is on the core clock, off during reset
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	a_grant_pass: assert property (bus_request_n_o && $past(bus_request_n_o)
		&& $past(nrst_i, 2) && !$past(bus_grant_in_n_i, 2)
		|-> !bus_grant_out_n_o)
		else $error("grant not passed on");
	a_grant_block: assert property (!bus_request_n_o |-> bus_grant_out_n_o)
		else $error("grant passed while requesting");
	a_ack_pass: assert property (int_request_n_o && $past(int_request_n_o)
		&& $past(nrst_i, 2) && !$past(int_ack_in_n_i, 2)
		|-> !int_ack_out_n_o)
		else $error("ack not passed on");
	a_ack_block: assert property (!int_request_n_o |-> int_ack_out_n_o)
		else $error("ack passed while interrupting");
	a_stop_bus: assert property ((!stop_request_n_i && bus_request_n_o)[*4]
		|=> bus_request_n_o)
		else $error("bus request under stop");
	a_stop_int: assert property ((!stop_request_n_i && int_request_n_o)[*4]
		|=> int_request_n_o)
		else $error("interrupt under stop");
	a_dcs_low: assert property ((!chip_select_n_i && !reg_select_i[3])[*3]
		|-> !periph_select_n_o)
		else $error("peripheral select missing");
	a_dcs_high: assert property ((!chip_select_n_i && reg_select_i[3])[*3]
		##0 bus_request_n_o |-> periph_select_n_o)
		else $error("peripheral select on own access");
	a_dal_float: assert property ((!chip_select_n_i && !reg_select_i[3]
		&& bus_request_n_o && int_ack_in_n_i)[*4] |-> !data_access_lines_oe_o)
		else $error("data lines driven for peripheral");
	a_dir_mem: assert property (!mem_sync_n_o |-> mem_write_n_o == !xfer_dir_o
		&& mem_read_n_o == xfer_dir_o)
		else $error("memory strobe against direction");
	a_sync_lal: assert property ($fell(mem_sync_n_o)
		|-> !$past(addr_low_strobe_n_o))
		else $error("sync without low address");
	a_lal_pulse: assert property ($fell(addr_low_strobe_n_o)
		|=> addr_low_strobe_n_o)
		else $error("low address strobe too long");
endmodule // bwd_dmac_asserts
bind bwd_dmac bwd_dmac_asserts chk_i (.*);
`default_nettype wire

// ===== bwd_far_model.sv
// bwd_far_model: bus arbiter and memory on the far side
// assumes open-drain lines with pull-ups; high means released
`timescale 1ns/100ps
`default_nettype none
module bwd_far_model (
	input wire logic core_clk_i,
	input wire logic bus_request_n_i,
	input wire logic mem_sync_n_i,
	input wire logic slow_i,
	output logic bus_grant_n_o,
	output logic reply_n_o
);
	int cg = 0; // cycles of bus request
	int cr = 0; // cycles of memory sync
	// count how long each request has stood
	always @(posedge core_clk_i) begin
		cg <= bus_request_n_i ? 0 : cg + 1;
		cr <= mem_sync_n_i ? 0 : cr + 1;
	end
	// grant after a prompt or slow wait
	assign bus_grant_n_o = !(cg > (slow_i ? 6 : 1));
	// memory answers the sync, releases with it
	assign reply_n_o = !(cr > (slow_i ? 9 : 1));
endmodule // bwd_far_model
`default_nettype wire

// ===== bwd_dmac_tb_top.sv
// bwd_dmac_tb_top: self-checking bench for the dma controller
// assumes bwd_far_model answers grant and memory reply
`timescale 1ns/100ps
`default_nettype none
module bwd_dmac_tb_top;
	import bwd_pkg::*;
	logic core_clk_i = 0, nrst_i = 0, xfer_request_in_i = 0;
	logic stop_request_n_i = 1, int_ack_in_n_i = 1, periph_int_in_i = 0;
	logic byte_word_sel_i = 1, auto_boot_load_i = 0, data_polarity_sel_i = 1;
	logic chip_select_n_i = 1, reply_n_i, bus_grant_in_n_i;
	logic read_strobe_n_i, write_strobe_n_i, read_strobe_n_o;
	logic read_strobe_n_oe_o, write_strobe_n_o, write_strobe_n_oe_o;
	logic reply_n_o, reply_n_oe_o, data_access_lines_oe_o;
	logic addr_extension_bit_o, bus_request_n_o, addr_low_strobe_n_o;
	logic bus_grant_out_n_o, int_ack_out_n_o, periph_select_n_o;
	logic mem_read_n_o, mem_read_n_oe_o, mem_write_n_o, mem_write_n_oe_o;
	logic mem_sync_n_o, mem_sync_n_oe_o, int_request_n_o, int_request_n_oe_o;
	logic xfer_dir_o, end_of_block_o;
	logic [3:0] reg_select_i = 4'h8;
	logic [7:0] data_access_lines_i, data_access_lines_o;
	logic [7:0] cdal = 8'h00, pat = 8'h00, idv; // host data, idle pattern
	logic c_re = 1, c_we = 1, c_oe = 0, g_n = 1, slow = 0, far_g, far_r;
	logic got = 0; // one note per read answer
	logic [7:0] expq[$]; // expected read data, oldest first
	logic [17:0] ma;
	int n_errors = 0, samples_checked = 0;
	// wired lines with pull-ups; undriven data changes every cycle
	assign read_strobe_n_i = c_re & (read_strobe_n_o | !read_strobe_n_oe_o);
	assign write_strobe_n_i = c_we & (write_strobe_n_o | !write_strobe_n_oe_o);
	assign reply_n_i = far_r & (reply_n_o | !reply_n_oe_o);
	assign bus_grant_in_n_i = far_g & g_n;
	assign data_access_lines_i = c_oe ? cdal : pat;
	always #4 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) pat <= pat + 8'h5b;
	bwd_dmac uut (.*);
	bwd_far_model far (.core_clk_i, .bus_request_n_i(bus_request_n_o),
		.mem_sync_n_i(mem_sync_n_o), .slow_i(slow),
		.bus_grant_n_o(far_g), .reply_n_o(far_r));
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// watcher: a read answer takes the oldest note
	always @(posedge core_clk_i) begin
		if (reply_n_oe_o === 1'b1 && data_access_lines_oe_o === 1'b1) begin
			if (!got && expq.size() > 0)
				chk(data_access_lines_o, expq.pop_front());
			got <= 1;
		end else begin
			got <= 0;
		end
	end
	function automatic logic sig(input int k);
		case (k)
			0: return bus_request_n_o;
			1: return addr_low_strobe_n_o;
			2: return mem_sync_n_o;
			default: return reply_n_i;
		endcase
	endfunction
	// bounded wait for a line to reach a level
	task automatic wt(input int k, input logic v);
		int i;
		for (i = 0; i < 900 && sig(k) !== v; i++) begin
			@(posedge core_clk_i);
			#1;
		end
		if (i == 900) begin
			n_errors++;
			close_out();
		end
	endtask
	task automatic cpu(input logic w, input logic [2:0] r, input logic [7:0] d);
		@(posedge core_clk_i);
		#1;
		// chip select comes with the strobe
		chip_select_n_i = 0;
		reg_select_i = {1'b1, r};
		// host data follows the selected bus polarity
		cdal = d ^ {8{!data_polarity_sel_i}};
		c_oe = w;
		c_we = !w;
		c_re = w;
		wt(3, 0);
		@(posedge core_clk_i);
		#1;
		{chip_select_n_i, c_re, c_we, c_oe} = 4'he;
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	task automatic rd(input logic [2:0] r, input logic [7:0] e);
		expq.push_back(e);
		cpu(0, r, 8'h00);
	endtask
	task automatic rst();
		nrst_i = 0;
		repeat (5) @(posedge core_clk_i);
		#1;
		nrst_i = 1;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask
	task automatic dma(input logic bw, input logic iom);
		logic [8:0] pm; // inversion mask of the data lines
		pm = {9{!data_polarity_sel_i}};
		ma = 18'($urandom) & {17'h1ffff, bw};
		byte_word_sel_i = bw;
		slow = !bw;
		cpu(1, REG_MA_LO, ma[7:0]);
		cpu(1, REG_MA_HI, ma[15:8]);
		cpu(1, REG_MA_EXT, {6'h00, ma[17:16]});
		cpu(1, REG_TC_LO, 8'hff);
		cpu(1, REG_TC_HI, 8'hff);
		stop_request_n_i = 0;
		cpu(1, REG_CTRL, {3'h0, iom, 4'h9});
		chk(xfer_dir_o, iom);
		xfer_request_in_i = 1;
		repeat (12) @(posedge core_clk_i);
		#1;
		chk(bus_request_n_o, 1);
		stop_request_n_i = 1;
		wt(0, 0);
		chk({addr_extension_bit_o, data_access_lines_o}, {ma[17], ma[15:8]} ^ pm);
		wt(1, 0);
		chk({addr_extension_bit_o, data_access_lines_o}, {ma[16], ma[7:0]} ^ pm);
		wt(2, 0);
		chk({mem_read_n_o, mem_write_n_o}, {iom, !iom});
		chk(iom ? read_strobe_n_o : write_strobe_n_o, 0);
		chk({read_strobe_n_oe_o, write_strobe_n_oe_o}, {iom, !iom});
		chk({mem_sync_n_oe_o, periph_select_n_o}, 2'h2);
		chk({mem_read_n_oe_o, mem_write_n_oe_o}, {!iom, iom});
		xfer_request_in_i = 0;
		wt(0, 1);
		chk(end_of_block_o, 1);
		repeat (4) @(posedge core_clk_i);
		#1;
		chk({int_request_n_o, int_request_n_oe_o}, 2'h1);
		rd(REG_MA_LO, (ma[7:0] + (bw ? 8'h01 : 8'h02)) ^ pm[7:0]);
	endtask
	initial begin
		idv = 8'($urandom(32'h079a41e6));
		rst();
		rd(REG_CTRL, CTRL_RST);
		rd(REG_STAT, 8'h71);
		chk({xfer_dir_o, end_of_block_o}, 2'h2);
		auto_boot_load_i = 1;
		repeat (4) @(posedge core_clk_i);
		#1;
		auto_boot_load_i = 0;
		rd(REG_CTRL, CTRL_RST | CTRL_AUTO);
		// count write ignored while running
		cpu(1, REG_TC_LO, 8'h5a);
		rd(REG_TC_LO, TC_RST[7:0]);
		cpu(1, REG_CTRL, 8'h00);
		chk(xfer_dir_o, 0);
		cpu(1, REG_ID, idv);
		rd(REG_ID, idv);
		data_polarity_sel_i = 0;
		rd(REG_ID, ~idv);
		data_polarity_sel_i = 1;
		// both acknowledge chains pass through while idle
		{g_n, int_ack_in_n_i} = 2'h0;
		repeat (4) @(posedge core_clk_i);
		#1;
		chk({bus_grant_out_n_o, int_ack_out_n_o}, 2'h0);
		{g_n, int_ack_in_n_i} = 2'h3;
		// device interrupt needs its enable, clears by status write
		periph_int_in_i = 1;
		repeat (4) @(posedge core_clk_i);
		#1;
		chk(int_request_n_o, 1);
		cpu(1, REG_CTRL, 8'h02);
		chk(int_request_n_o, 0);
		rd(REG_STAT, 8'h03);
		periph_int_in_i = 0;
		cpu(1, REG_STAT, 8'h00);
		chk(int_request_n_o, 1);
		// host reads a peripheral register
		{chip_select_n_i, c_re} = 2'h0;
		reg_select_i = 4'h5;
		repeat (5) @(posedge core_clk_i);
		#1;
		chk({periph_select_n_o, data_access_lines_oe_o, reply_n_i}, 3'h1);
		{chip_select_n_i, c_re} = 2'h3;
		reg_select_i = 4'h8;
		dma(1, 1);
		// interrupt acknowledge with read strobe
		{int_ack_in_n_i, c_re} = 2'h0;
		repeat (5) @(posedge core_clk_i);
		#1;
		chk({data_access_lines_oe_o, data_access_lines_o}, {1'b1, idv});
		chk(int_ack_out_n_o, 1);
		{int_ack_in_n_i, c_re} = 2'h3;
		rst();
		// second block with a complemented data bus
		data_polarity_sel_i = 0;
		dma(0, 0);
		chk(18'(expq.size()), 18'h00000);
		close_out();
	end
	// overall hang limit
	initial begin
		#400000;
		n_errors++;
		close_out();
	end
endmodule // bwd_dmac_tb_top
`default_nettype wire
